// file: design/i2csq_top.sv
`timescale 1ns/1ps
module i2csq_top import i2csq_pkg::*; (
	// clocks and reset
	input  wire logic                mclk,
	input  wire logic                rst_n,
	input  wire logic                link_clk,
	// bus pins, open drain
	input  wire logic                scl_i,
	input  wire logic                sda_i,
	output logic                     sda_o,
	output logic                     sda_oe,
	// converter sample stream
	input  wire logic                sample_valid,
	input  wire logic [SAMPLE_W-1:0] sample_data,
	input  wire logic                sample_first_ch,
	// event sources
	input  wire logic                ev_adc_done,
	input  wire logic                ev_seq_done,
	input  wire logic                ev_ltf_done,
	input  wire logic                ev_limit_cross,
	input  wire logic                ev_clip,
	input  wire logic                ev_supply_low,
	// control and interrupt
	output logic                     ldo_en,
	output logic                     osc_en,
	output logic                     int_n
);
	// ---------------- link domain ----------------
	logic [1:0]   lrst_sync;
	logic         link_rst_n;
	logic [1:0]   pin_s1;
	logic [1:0]   pin_s2;
	logic [1:0]   pin_s3;
	logic         scl, sda, scl_rise, scl_fall, start_det, stop_det;
	i2csq_state_e st_reg, st_next;
	logic [3:0]   cnt_reg, cnt_next;
	logic [7:0]   sh_reg, sh_next;
	logic [7:0]   tx_reg, tx_next;
	logic [7:0]   word_pointer_reg, word_pointer_next, ptr_inc;
	logic         drv_reg, drv_next;
	logic         more_reg, more_next;
	logic         req_fire;
	logic         req_tgl_reg;
	logic         req_wr_reg, req_wr_next;
	logic [7:0]   req_addr_reg, req_addr_next;
	logic [7:0]   req_wdata_reg, req_wdata_next;
	logic         ack_tgl_reg, ack_s1, ack_s2, ack_s3;
	logic [7:0]   rsp_reg, rsp_m_reg;

	// reset release reaches the link logic through two flops
	always_ff @(posedge link_clk) begin
		lrst_sync <= {lrst_sync[0], rst_n};
	end
	assign link_rst_n = lrst_sync[1];

	// pins are oversampled; filtering spikes is left to the pad RC
	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			pin_s1 <= 2'h3;
			pin_s2 <= 2'h3;
			pin_s3 <= 2'h3;
		end else begin
			pin_s1 <= {scl_i, sda_i};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	// bus conditions from the synchronised pins
	assign scl       = pin_s2[1];
	assign sda       = pin_s2[0];
	assign scl_rise  = scl & ~pin_s3[1];
	assign scl_fall  = ~scl & pin_s3[1];
	assign start_det = scl & pin_s3[1] & pin_s3[0] & ~sda;
	assign stop_det  = scl & pin_s3[1] & ~pin_s3[0] & sda;
	assign ptr_inc   = word_pointer_reg + 8'h01;
	assign sda_o     = 1'b0;
	assign sda_oe    = drv_reg;

	// protocol engine; data changes only while scl is low
	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		tx_next = tx_reg;
		word_pointer_next = word_pointer_reg;
		drv_next = drv_reg;
		more_next = more_reg;
		req_fire = 1'b0;
		req_wr_next = req_wr_reg;
		req_addr_next = req_addr_reg;
		req_wdata_next = req_wdata_reg;
		if (start_det) begin
			st_next = ST_ADDR;
			cnt_next = '0;
			drv_next = 1'b0;
		end else if (stop_det) begin
			st_next = ST_IDLE;
			drv_next = 1'b0;
		end else begin
			case (st_reg)
				ST_ADDR, ST_WORD, ST_WDATA: begin
					if (scl_rise) begin
						sh_next = {sh_reg[6:0], sda};
						cnt_next = cnt_reg + 4'h1;
					end
					if (scl_fall && cnt_reg == BYTE_BITS) begin
						cnt_next = '0;
						drv_next = 1'b1;
						if (st_reg == ST_ADDR) begin
							more_next = (sh_reg == READ_SELECT_BYTE);
							if (sh_reg == READ_SELECT_BYTE) begin
								st_next = ST_ADDR_ACK;
								req_fire = 1'b1;
								req_wr_next = 1'b0;
								req_addr_next = word_pointer_reg;
							end else if (sh_reg == WRITE_SELECT_BYTE) begin
								st_next = ST_ADDR_ACK;
							end else begin
								st_next = ST_IDLE;
								drv_next = 1'b0;
							end
						end else if (st_reg == ST_WORD) begin
							st_next = ST_WORD_ACK;
							word_pointer_next = sh_reg;
						end else begin
							st_next = ST_WDATA_ACK;
							req_fire = 1'b1;
							req_wr_next = 1'b1;
							req_addr_next = word_pointer_reg;
							req_wdata_next = sh_reg;
							word_pointer_next = ptr_inc;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall && more_reg) begin
						st_next = ST_RDATA;
						tx_next = rsp_reg;
						drv_next = ~rsp_reg[7];
					end else if (scl_fall) begin
						st_next = ST_WORD;
						drv_next = 1'b0;
					end
				end
				ST_WORD_ACK, ST_WDATA_ACK: begin
					if (scl_fall) begin
						st_next = ST_WDATA;
						drv_next = 1'b0;
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						cnt_next = cnt_reg + 4'h1;
						tx_next = {tx_reg[6:0], 1'b0};
						drv_next = ~tx_reg[6];
						if (cnt_reg == BYTE_BITS - 4'h1) begin
							st_next = ST_RDATA_ACK;
							drv_next = 1'b0;
						end
					end
				end
				ST_RDATA_ACK: begin
					if (scl_rise) begin
						word_pointer_next = ptr_inc;
						more_next = ~sda;
						req_fire = ~sda; // fetch only after an ack, so no stray pop
						req_wr_next = 1'b0;
						req_addr_next = ptr_inc;
					end
					if (scl_fall && more_reg) begin
						st_next = ST_RDATA;
						cnt_next = '0;
						tx_next = rsp_reg;
						drv_next = ~rsp_reg[7];
					end else if (scl_fall) begin
						st_next = ST_IDLE;
					end
				end
				default: begin
					st_next = st_reg;
				end
			endcase
		end
	end

	// link state registers
	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			st_reg <= ST_IDLE;
			cnt_reg <= '0;
			sh_reg <= RST_BYTE;
			tx_reg <= RST_BYTE;
			word_pointer_reg <= RST_BYTE;
			drv_reg <= 1'b0;
			more_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			tx_reg <= tx_next;
			word_pointer_reg <= word_pointer_next;
			drv_reg <= drv_next;
			more_reg <= more_next;
		end
	end

	// request toggle with held words; answer taken on the returned toggle
	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			req_tgl_reg <= 1'b0;
			req_wr_reg <= 1'b0;
			req_addr_reg <= RST_BYTE;
			req_wdata_reg <= RST_BYTE;
			{ack_s1, ack_s2, ack_s3} <= 3'h0;
			rsp_reg <= RST_BYTE;
		end else begin
			req_tgl_reg <= req_tgl_reg ^ req_fire;
			req_wr_reg <= req_wr_next;
			req_addr_reg <= req_addr_next;
			req_wdata_reg <= req_wdata_next;
			{ack_s1, ack_s2, ack_s3} <= {ack_tgl_reg, ack_s1, ack_s2};
			if (ack_s2 ^ ack_s3) rsp_reg <= rsp_m_reg;
		end
	end

	// ---------------- core domain ----------------
	logic           hs_s1, hs_s2, hs_s3, acc, acc_wr, acc_rd;
	logic [7:0]     rd_mux, status_view, pending, evt_set, evt_clr;
	logic [7:0]     limit_reg, mask_reg, evt_reg;
	logic [1:0]     ctrl_reg;
	logic           marker_reg, entry_mark, int_n_reg;
	logic           q_pop, q_clear, q_ovf, q_empty, level_evt;
	logic [QDW-1:0] q_head, q_push_data;
	logic [QLW-1:0] q_level;

	// access decode; address and data words are held by the link side
	assign acc      = hs_s2 ^ hs_s3;
	assign acc_wr   = acc & req_wr_reg;
	assign acc_rd   = acc & ~req_wr_reg;
	assign q_empty  = (q_level == '0);
	assign q_pop    = acc_rd && req_addr_reg == ADDR_QHIGH && !q_empty;
	assign q_clear  = acc_wr && req_addr_reg == ADDR_QCTRL && req_wdata_reg[BIT_CLEAR];
	assign evt_clr  = (acc_wr && req_addr_reg == ADDR_STATUS) ? req_wdata_reg : RST_BYTE;

	// events: level bit is live, the rest sticky with set over clear
	assign level_evt = q_level > {1'b0, limit_reg[LIMIT_W-1:0]};
	assign evt_set = {ev_supply_low, ev_clip, q_ovf, 1'b0,
		ev_limit_cross, ev_ltf_done, ev_seq_done, ev_adc_done};
	assign status_view = evt_reg | ({7'h00, level_evt} << EV_LEVEL);
	assign pending = status_view & mask_reg;

	// entry packing: result times four, marker in bit 0
	assign entry_mark  = sample_first_ch ? marker_reg : ~marker_reg;
	assign q_push_data = {sample_data, 1'b0, entry_mark};

	// read selection; unmapped and write-only addresses read zero
	assign rd_mux =
		(req_addr_reg == ADDR_CONTROL) ? {6'h00, ctrl_reg} :
		(req_addr_reg == ADDR_LIMIT)   ? limit_reg :
		(req_addr_reg == ADDR_STATUS)  ? status_view :
		(req_addr_reg == ADDR_QSTAT)   ? {evt_reg[EV_OVF], q_level} :
		(req_addr_reg == ADDR_MASK)    ? mask_reg :
		(req_addr_reg == ADDR_PEND)    ? pending :
		(req_addr_reg == ADDR_QLOW)    ? (q_empty ? RST_BYTE : q_head[7:0]) :
		(req_addr_reg == ADDR_QHIGH)   ? (q_empty ? RST_BYTE : q_head[15:8]) :
		RST_BYTE;

	assign ldo_en = ctrl_reg[BIT_LDO];
	assign osc_en = ctrl_reg[BIT_OSC]; // host must set it first
	assign int_n  = int_n_reg;

	// request toggle crossing and answer
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			{hs_s1, hs_s2, hs_s3} <= 3'h0;
			ack_tgl_reg <= 1'b0;
			rsp_m_reg <= RST_BYTE;
		end else begin
			{hs_s1, hs_s2, hs_s3} <= {req_tgl_reg, hs_s1, hs_s2};
			if (acc) ack_tgl_reg <= hs_s2;
			if (acc_rd) rsp_m_reg <= rd_mux;
		end
	end

	// software registers, events and interrupt pin
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl_reg <= 2'h0;
			limit_reg <= RST_BYTE;
			mask_reg <= RST_BYTE;
			evt_reg <= RST_BYTE;
			marker_reg <= 1'b0;
			int_n_reg <= 1'b1;
		end else begin
			if (acc_wr && req_addr_reg == ADDR_CONTROL) ctrl_reg <= req_wdata_reg[1:0];
			if (acc_wr && req_addr_reg == ADDR_LIMIT) limit_reg <= req_wdata_reg;
			if (acc_wr && req_addr_reg == ADDR_MASK) mask_reg <= req_wdata_reg;
			evt_reg <= (evt_reg & ~evt_clr) | evt_set;
			if (sample_valid) marker_reg <= entry_mark;
			int_n_reg <= ~|pending;
		end
	end

	i2csq_queue u_queue (
		.clk       (mclk),
		.rst_n     (rst_n),
		.push      (sample_valid),
		.push_data (q_push_data),
		.pop       (q_pop),
		.clear     (q_clear),
		.head      (q_head),
		.level     (q_level),
		.overflow  (q_ovf)
	);

	// checks
	a_level_event: assert property (@(posedge mclk) disable iff (!rst_n)
		q_level == {1'b0, limit_reg[LIMIT_W-1:0]} + 7'h01 |-> status_view[EV_LEVEL])
		else $error("level event missing above limit");
	a_high_pops: assert property (@(posedge mclk) disable iff (!rst_n)
		q_pop && !sample_valid |=> q_level == $past(q_level) - 7'h01)
		else $error("high byte read did not pop");
	a_low_nopop: assert property (@(posedge mclk) disable iff (!rst_n)
		acc_rd && req_addr_reg == ADDR_QLOW && !sample_valid |=> $stable(q_level))
		else $error("low byte read changed level");
	a_empty_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		acc_rd && q_empty && req_addr_reg == ADDR_QHIGH |=> rsp_m_reg == RST_BYTE)
		else $error("empty read not zero");
	a_ovf_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
		evt_reg[EV_OVF] && !evt_clr[EV_OVF] |=> evt_reg[EV_OVF])
		else $error("overrun event lost");
	a_int_low: assert property (@(posedge mclk) disable iff (!rst_n)
		|pending |=> !int_n) else $error("interrupt not driven");
	a_mark_toggle: assert property (@(posedge mclk) disable iff (!rst_n)
		sample_valid && !sample_first_ch |-> q_push_data[0] != marker_reg)
		else $error("marker did not toggle");
	a_ptr_incr: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		st_reg == ST_WDATA && scl_fall && cnt_reg == BYTE_BITS && !start_det && !stop_det
		|=> word_pointer_reg == $past(word_pointer_reg) + 8'h01)
		else $error("pointer not incremented");
	a_ack_drive: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		st_reg == ST_ADDR_ACK || st_reg == ST_WORD_ACK || st_reg == ST_WDATA_ACK |-> drv_reg)
		else $error("ack not driven");
	c_queue_pop: cover property (@(posedge mclk) disable iff (!rst_n) q_pop);
	c_overflow: cover property (@(posedge mclk) disable iff (!rst_n) q_ovf);
	c_read_data: cover property (@(posedge link_clk) disable iff (!link_rst_n)
		st_reg == ST_RDATA_ACK && more_reg);
	c_write_data: cover property (@(posedge link_clk) disable iff (!link_rst_n)
		st_reg == ST_WDATA_ACK);
endmodule // i2csq_top

// file: design/i2csq_pkg.sv
package i2csq_pkg;
	// bus select codes
	localparam logic [6:0] DEV_ADDR          = 7'h30;
	localparam logic [7:0] WRITE_SELECT_BYTE = {DEV_ADDR, 1'b0};
	localparam logic [7:0] READ_SELECT_BYTE  = {DEV_ADDR, 1'b1};
	localparam logic [3:0] BYTE_BITS         = 4'h8;
	// bus rates the oversampling front end must follow, in kHz
	localparam int SCL_FAST_KHZ = 400;
	localparam int SCL_STD_KHZ  = 100;

	// register map
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_LIMIT   = 8'h78;
	localparam logic [7:0] ADDR_QCTRL   = 8'h79;
	localparam logic [7:0] ADDR_STATUS  = 8'ha0;
	localparam logic [7:0] ADDR_QSTAT   = 8'ha3;
	localparam logic [7:0] ADDR_MASK    = 8'ha8;
	localparam logic [7:0] ADDR_PEND    = 8'ha9;
	localparam logic [7:0] ADDR_QLOW    = 8'hfe;
	localparam logic [7:0] ADDR_QHIGH   = 8'hff;
	localparam logic [7:0] RST_BYTE     = 8'h00;

	// field positions
	localparam int BIT_LDO   = 0;
	localparam int BIT_OSC   = 1;
	localparam int BIT_CLEAR = 0;
	localparam int LIMIT_W   = 6;
	localparam int EV_ADC    = 0;
	localparam int EV_SEQ    = 1;
	localparam int EV_LTF    = 2;
	localparam int EV_THR    = 3;
	localparam int EV_LEVEL  = 4;
	localparam int EV_OVF    = 5;
	localparam int EV_CLIP   = 6;
	localparam int EV_SUPPLY = 7;

	// sample queue geometry
	localparam int QDEPTH   = 64;
	localparam int QAW      = 6;
	localparam int QLW      = 7;
	localparam int QDW      = 16;
	localparam int SAMPLE_W = 14;

	typedef enum {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WORD, ST_WORD_ACK,
		ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
	} i2csq_state_e;
endpackage

// file: design/i2csq_queue.sv
`timescale 1ns/1ps
module i2csq_queue import i2csq_pkg::*; (
	// clock and reset
	input  wire logic           clk,
	input  wire logic           rst_n,
	// requests
	input  wire logic           push,
	input  wire logic [QDW-1:0] push_data,
	input  wire logic           pop,
	input  wire logic           clear,
	// state
	output logic      [QDW-1:0] head,
	output logic      [QLW-1:0] level,
	output logic                overflow
);
	logic [QDW-1:0] mem [QDEPTH];
	logic [QAW-1:0] wr_ptr_reg;
	logic [QAW-1:0] rd_ptr_reg;
	logic [QLW-1:0] level_reg;
	logic [QLW-1:0] level_next;
	logic           full;
	logic           empty;
	logic           do_push;
	logic           do_pop;

	// a full queue still takes a push when the same cycle pops
	assign full     = (level_reg == QLW'(QDEPTH));
	assign empty    = (level_reg == '0);
	assign do_pop   = pop & ~empty & ~clear;
	assign do_push  = push & (~full | do_pop) & ~clear;
	assign overflow = push & full & ~do_pop & ~clear;
	assign head     = mem[rd_ptr_reg];
	assign level    = level_reg;
	assign level_next = level_reg + QLW'(do_push) - QLW'(do_pop);

	// storage, first in first out by wrapping pointers
	always_ff @(posedge clk) begin
		if (do_push) mem[wr_ptr_reg] <= push_data;
	end

	// pointers and fill level, clear empties the queue
	always_ff @(posedge clk) begin
		if (!rst_n || clear) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			level_reg  <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + QAW'(do_push);
			rd_ptr_reg <= rd_ptr_reg + QAW'(do_pop);
			level_reg  <= level_next;
		end
	end

	a_level_bound: assert property (@(posedge clk) disable iff (!rst_n)
		level_reg <= QLW'(QDEPTH)) else $error("queue level beyond depth");
	a_clear_empties: assert property (@(posedge clk) disable iff (!rst_n)
		clear |=> level_reg == '0) else $error("clear left entries");
	a_full_overflow: assert property (@(posedge clk) disable iff (!rst_n)
		overflow |=> level_reg == QLW'(QDEPTH)) else $error("overflow without full queue");
endmodule // i2csq_queue

// file: dv/i2csq_host.sv
`timescale 1ns/1ps
module i2csq_host (
	// timing reference
	input  wire logic mclk,
	// resolved data wire
	input  wire logic sda_line,
	// master pins; sda_low pulls the open-drain wire down
	output logic      scl,
	output logic      sda_low
);
	int q = 38; // quarter bit time in mclk cycles; a whole bit spans about 20 link periods

	// bus idle: scl driven high, sda left to the pull-up
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic qw();
		repeat (q) @(negedge mclk);
	endtask

	// start or repeated start, leaves scl low
	task automatic start_c();
		sda_low = 1'b0;
		qw();
		scl = 1'b1;
		qw();
		sda_low = 1'b1;
		qw();
		scl = 1'b0;
		qw();
	endtask

	task automatic stop_c();
		sda_low = 1'b1;
		qw();
		scl = 1'b1;
		qw();
		sda_low = 1'b0;
		qw();
	endtask

	// data only changes while scl is low
	task automatic bit_out(input logic b);
		sda_low = ~b;
		qw();
		scl = 1'b1;
		qw();
		qw();
		scl = 1'b0;
		qw();
	endtask

	task automatic bit_in(output logic b);
		sda_low = 1'b0;
		qw();
		scl = 1'b1;
		qw();
		b = sda_line;
		qw();
		scl = 1'b0;
		qw();
	endtask

	task automatic send(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) bit_out(d[i]);
		bit_in(b);
		ack = ~b;
	endtask

	// the last byte of a read gets a not-acknowledge
	task automatic recv(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) bit_in(d[i]);
		bit_out(last);
	endtask
endmodule // i2csq_host

// file: dv/i2csq_top_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH t=%0t got %h exp %h line %0d", $time, g, e, `__LINE__); end end
module i2csq_top_bench import i2csq_pkg::*;;
	logic                mclk = 1'b0;
	logic                link_clk = 1'b0;
	logic                rst_n;
	logic                scl, sda_low, sda_line, sda_oe, sda_o;
	logic                sample_valid, sample_first_ch;
	logic [SAMPLE_W-1:0] sample_data;
	logic [5:0]          ev;
	logic                ldo_en, osc_en, int_n, m;
	logic [7:0]          rdat [4];
	logic [13:0]         sd [3] = '{14'h1234, 14'h2abc, 14'h0155};
	logic [2:0]          fc = 3'b100;
	int                  err_total = 0;
	int                  tests_run = 0;

	// core clock and an unrelated link clock
	always #2 mclk = ~mclk;
	initial begin
		#7;
		forever #15 link_clk = ~link_clk;
	end

	// open-drain wire with pull-up
	assign sda_line = ~(sda_low | (sda_oe & ~sda_o));

	i2csq_host host_u (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

	i2csq_top dut_u (
		.mclk(mclk), .rst_n(rst_n), .link_clk(link_clk),
		.scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
		.sample_valid(sample_valid), .sample_data(sample_data),
		.sample_first_ch(sample_first_ch),
		.ev_adc_done(ev[0]), .ev_seq_done(ev[1]), .ev_ltf_done(ev[2]),
		.ev_limit_cross(ev[3]), .ev_clip(ev[4]), .ev_supply_low(ev[5]),
		.ldo_en(ldo_en), .osc_en(osc_en), .int_n(int_n)
	);

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic sel(input logic [7:0] b, input logic exp_ack);
		logic a;
		host_u.send(b, a);
		`CHK(a, exp_ack)
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1,
		input int n);
		host_u.start_c();
		sel(WRITE_SELECT_BYTE, 1'b1);
		sel(a, 1'b1);
		sel(d0, 1'b1);
		if (n > 1) sel(d1, 1'b1);
		host_u.stop_c();
	endtask

	// cur skips the word address phase
	task automatic rd(input logic [7:0] a, input int n, input logic cur);
		if (!cur) begin
			host_u.start_c();
			sel(WRITE_SELECT_BYTE, 1'b1);
			sel(a, 1'b1);
		end
		host_u.start_c();
		sel(READ_SELECT_BYTE, 1'b1);
		for (int i = 0; i < n; i++) host_u.recv(i == n - 1, rdat[i]);
		host_u.stop_c();
	endtask

	task automatic push(input logic [13:0] d, input logic f);
		sample_data = d;
		sample_first_ch = f;
		sample_valid = 1'b1;
		@(negedge mclk);
		sample_valid = 1'b0;
		@(negedge mclk); // one idle cycle so back-to-back pushes stay distinct pulses
	endtask

	// hang guard, about a third above the expected run
	initial begin
		#600000;
		err_total++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		stop_test();
	end

	initial begin
		rst_n = 1'b0;
		sample_valid = 1'b0;
		sample_data = '0;
		sample_first_ch = 1'b0;
		ev = '0;
		// long enough for the link side's two-flop reset copy
		repeat (40) @(negedge mclk);
		rst_n = 1'b1;
		repeat (300) @(negedge mclk);
		`CHK({int_n, ldo_en, osc_en, sda_oe, sda_o}, 5'b10000)
		$display("test reset done");
		host_u.q = 156;
		wr_reg(ADDR_CONTROL, 8'h03, 8'h00, 1);
		`CHK({ldo_en, osc_en}, 2'b11)
		host_u.q = 38;
		host_u.start_c();
		sel(8'h62, 1'b0);
		host_u.stop_c();
		$display("test select done");
		wr_reg(ADDR_LIMIT, 8'h02, 8'h01, 2);
		rd(ADDR_LIMIT, 2, 1'b0);
		`CHK({rdat[0], rdat[1]}, 16'h0200)
		$display("test page done");
		for (int k = 0; k < 3; k++) push(sd[k], fc[k]);
		wr_reg(ADDR_MASK, 8'h10, 8'h00, 1);
		`CHK(int_n, 1'b0)
		rd(ADDR_QSTAT, 1, 1'b0);
		`CHK(rdat[0], 8'h03)
		for (int k = 0; k < 3; k++) begin
			rd(ADDR_QLOW, 2, 1'b0);
			`CHK(rdat[0][7:1], {sd[k][5:0], 1'b0})
			`CHK(rdat[1], sd[k][13:6])
			if (k > 0) `CHK(rdat[0][0], fc[k] ? m : ~m)
			if (k == 0) `CHK(int_n, 1'b1)
			m = rdat[0][0];
		end
		$display("test queue done");
		rd(ADDR_QLOW, 2, 1'b0);
		`CHK({rdat[0], rdat[1]}, 16'h0000)
		rd(8'h00, 1, 1'b1);
		`CHK(rdat[0], 8'h03)
		$display("test empty done");
		repeat (QDEPTH + 1) push(14'h0aaa, 1'b0);
		rd(ADDR_QSTAT, 1, 1'b0);
		`CHK(rdat[0], {1'b1, QLW'(QDEPTH)})
		wr_reg(ADDR_QCTRL, 8'h01, 8'h00, 1);
		rd(ADDR_QSTAT, 1, 1'b0);
		`CHK(rdat[0], 8'h80)
		wr_reg(ADDR_STATUS, 8'h20, 8'h00, 1);
		$display("test overrun done");
		ev = 6'h3f;
		@(negedge mclk);
		ev = '0;
		// overrun enabled too: a missed clear would show in pending and hold int_n low
		wr_reg(ADDR_MASK, 8'hef, 8'h00, 1);
		`CHK(int_n, 1'b0)
		rd(ADDR_MASK, 2, 1'b0);
		`CHK({rdat[0], rdat[1]}, 16'hefcf)
		wr_reg(ADDR_STATUS, 8'hcf, 8'h00, 1);
		`CHK(int_n, 1'b1)
		$display("test events done");
		stop_test();
	end
endmodule // i2csq_top_bench
